// [logic/lcadj_pkg.sv]
// package: register map, field layout, reset values and stream types
package lcadj_pkg;

  localparam logic [11:0] LCADJ_OFS_LUMA_OFFSET   = 12'h028;
  localparam logic [11:0] LCADJ_OFS_EVEN_CTRL     = 12'h02c;
  localparam logic [11:0] LCADJ_OFS_ODD_CTRL      = 12'h0ac;
  localparam logic [11:0] LCADJ_OFS_LUMA_GAIN_LO  = 12'h030;
  localparam logic [11:0] LCADJ_OFS_HSTART_DELAY  = 12'h040;
  localparam logic [11:0] LCADJ_OFS_STATUS        = 12'h044;

  localparam logic [7:0] LCADJ_RST_LUMA_OFFSET  = 8'h00;
  localparam logic [7:0] LCADJ_RST_CTRL         = 8'h20;
  localparam logic [7:0] LCADJ_RST_LUMA_GAIN_LO = 8'hd8;
  localparam logic [9:0] LCADJ_RST_HSTART_DELAY = 10'h078;

  localparam int LCADJ_BIT_NOTCH_BYPASS = 7;
  localparam int LCADJ_BIT_YC_INPUT     = 6;
  localparam int LCADJ_BIT_DECIM_BYPASS = 5;
  localparam int LCADJ_BIT_ORDER_INVERT = 4;
  localparam int LCADJ_BIT_LGAIN_TOP    = 2;
  localparam int LCADJ_BIT_UGAIN_TOP    = 1;
  localparam int LCADJ_BIT_VGAIN_TOP    = 0;

  // gain 216 is unity; 303/65536 approximates 1/216
  localparam logic [15:0] LCADJ_GAIN_RECIP = 16'h012f;
  localparam int          LCADJ_GAIN_SHIFT = 16;
  localparam logic [7:0]  LCADJ_LUMA_MAX   = 8'hff;

  typedef struct packed {
    logic       lineStart;
    logic       oddField;
    logic [7:0] luma;
    logic [7:0] cb;
    logic [7:0] cr;
  } lcadj_pix_t;

  typedef struct packed {
    logic       lineStart;
    logic       oddField;
    logic       active;
    logic       isCb;
    logic [7:0] luma;
    logic [7:0] chroma;
  } lcadj_vid_t;

endpackage

// [logic/lcadj_buf2.sv]
// DEPTH-entry valid/ready buffer, two entries by default
`timescale 1ns/10ps
module lcadj_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d;
  logic [PW-1:0]    rdPtr_q, rdPtr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             inReady_q, inReady_d;
  logic             outValid_q, outValid_d;
  logic             push;
  logic             pop;

  always_comb begin
    push    = inValid & inReady_q;
    pop     = outValid_q & outReady;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr_q + 1'b1);
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr_q + 1'b1);
    end
    if (push && !pop) begin
      count_d = CW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = CW'(count_q - 1'b1);
    end
    inReady_d  = (count_d != CW'(DEPTH));
    outValid_d = (count_d != '0);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      count_q    <= '0;
      inReady_q  <= 1'b1;
      outValid_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wrPtr_q    <= wrPtr_d;
      rdPtr_q    <= rdPtr_d;
      count_q    <= count_d;
      inReady_q  <= inReady_d;
      outValid_q <= outValid_d;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign inReady  = inReady_q;
  assign outValid = outValid_q;
  assign outData  = mem_q[rdPtr_q];
endmodule

// [logic/lcadj_top.sv]
// luma/chroma adjust: ahb-lite register bank and pixel datapath
// Notes on behaviour
// - luma offset is two's complement and added to every luma sample
// - offset spans -128..+127, one luma code per step
// - 0x80 is -128, 0xff is -1, 0x00 no change, 0x7f is +127
// - luma offset resets to zero
// - separate control copies for even and odd fields
// - both field control registers reset to 0x20
// - bit 7 clear keeps luma notch, set bypasses it
// - bit 6 set selects y/c and drops notch; clear selects composite, c adc off
// - bit 5 clear enables luma decimation filter, set disables it; resets set
// - bit 4 clear gives cb then cr; set gives cr then cb
// - order clear with even delay starts on cb; odd delay needs order set
// - bit 2 is top bit of luma gain
// - bits 1 and 0 are top bits of u and v gain
// - luma gain top bit plus low byte form 9-bit multiplier of luma
// - start delay counts pixels from sync fall to active video
`timescale 1ns/10ps
module lcadj_top
  import lcadj_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire lcadj_pkg::lcadj_pix_t pixIn,
  input  wire logic               pixInValid,
  output logic                    pixInReady,
  output lcadj_pkg::lcadj_vid_t   vidOut,
  output logic                    vidOutValid,
  input  wire logic               vidOutReady,
  output logic                    cAdcOn,
  output logic                    uGainTopBit,
  output logic                    vGainTopBit
);
  import lcadj_pkg::*;

  // bus state
  logic        wrPend_q, wrPend_d;
  logic [11:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        addrPhase;
  logic [11:0] rdAddr;
  logic        sizeOk;

  // register state
  logic [7:0]  lumaOffset_q, lumaOffset_d;
  logic [7:0]  ctrl_q [2];
  logic [7:0]  ctrl_d [2];
  logic [7:0]  lumaGainLow_q, lumaGainLow_d;
  logic [9:0]  hStartDelay_q, hStartDelay_d;

  // datapath state
  logic [7:0]  lumaPrev_q, lumaPrev_d;
  logic [7:0]  notchPrev_q, notchPrev_d;
  logic [9:0]  pixCount_q, pixCount_d;
  logic        curOdd_q, curOdd_d;
  logic        cAdcOn_q, cAdcOn_d;
  logic        uTop_q, uTop_d;
  logic        vTop_q, vTop_d;

  // datapath combinational
  logic [7:0]  actCtrl;
  logic        notchOn;
  logic        decimOn;
  logic [7:0]  lumaPrevUse;
  logic [7:0]  notchPrevUse;
  logic [7:0]  notchOut;
  logic [7:0]  decimOut;
  logic [8:0]  gain9;
  logic [16:0] gainProd;
  logic [32:0] scaled;
  logic [7:0]  gainOut;
  logic signed [9:0] offsetSum;
  logic [9:0]  pixIdx;
  lcadj_vid_t  vidNext;
  logic        bufInReady;
  logic        accept;

  // ahb-lite slave: zero wait state, always okay
  always_comb begin
    addrPhase = hsel & htrans[1] & hready;
    sizeOk    = (hsize == 3'h2);
    rdAddr    = {haddr[11:2], 2'b00};
    wrPend_d  = addrPhase & hwrite & sizeOk;
    wrAddr_d  = addrPhase ? rdAddr : wrAddr_q;
    rdata_d   = rdata_q;
    if (addrPhase && !hwrite) begin
      case (rdAddr)
        LCADJ_OFS_LUMA_OFFSET:  rdata_d = {24'h000000, lumaOffset_q};
        LCADJ_OFS_EVEN_CTRL:    rdata_d = {24'h000000, ctrl_q[0]};
        LCADJ_OFS_ODD_CTRL:     rdata_d = {24'h000000, ctrl_q[1]};
        LCADJ_OFS_LUMA_GAIN_LO: rdata_d = {24'h000000, lumaGainLow_q};
        LCADJ_OFS_HSTART_DELAY: rdata_d = {22'h0, hStartDelay_q};
        LCADJ_OFS_STATUS:       rdata_d = {20'h00000, cAdcOn_q, curOdd_q, pixCount_q};
        default:                rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
      rdata_q  <= 32'h00000000;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q  <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // register writes, data phase
  always_comb begin
    lumaOffset_d  = lumaOffset_q;
    ctrl_d[0]     = ctrl_q[0];
    ctrl_d[1]     = ctrl_q[1];
    lumaGainLow_d = lumaGainLow_q;
    hStartDelay_d = hStartDelay_q;
    if (wrPend_q) begin
      case (wrAddr_q)
        LCADJ_OFS_LUMA_OFFSET:  lumaOffset_d  = hwdata[7:0];
        LCADJ_OFS_EVEN_CTRL:    ctrl_d[0]     = hwdata[7:0];
        LCADJ_OFS_ODD_CTRL:     ctrl_d[1]     = hwdata[7:0];
        LCADJ_OFS_LUMA_GAIN_LO: lumaGainLow_d = hwdata[7:0];
        LCADJ_OFS_HSTART_DELAY: hStartDelay_d = hwdata[9:0];
        default:                lumaOffset_d  = lumaOffset_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lumaOffset_q  <= LCADJ_RST_LUMA_OFFSET;
      ctrl_q[0]     <= LCADJ_RST_CTRL;
      ctrl_q[1]     <= LCADJ_RST_CTRL;
      lumaGainLow_q <= LCADJ_RST_LUMA_GAIN_LO;
      hStartDelay_q <= LCADJ_RST_HSTART_DELAY;
    end else begin
      lumaOffset_q  <= lumaOffset_d;
      ctrl_q[0]     <= ctrl_d[0];
      ctrl_q[1]     <= ctrl_d[1];
      lumaGainLow_q <= lumaGainLow_d;
      hStartDelay_q <= hStartDelay_d;
    end
  end

  // pixel datapath
  always_comb begin
    accept  = pixInValid & bufInReady;
    actCtrl = pixIn.oddField ? ctrl_q[1] : ctrl_q[0];
    // notch only in composite mode and when not bypassed
    notchOn = ~actCtrl[LCADJ_BIT_NOTCH_BYPASS] & ~actCtrl[LCADJ_BIT_YC_INPUT];
    decimOn = ~actCtrl[LCADJ_BIT_DECIM_BYPASS];
    // history restarts at each line
    lumaPrevUse  = pixIn.lineStart ? pixIn.luma : lumaPrev_q;
    notchOut     = notchOn ? 8'((9'(pixIn.luma) + 9'(lumaPrevUse)) >> 1) : pixIn.luma;
    notchPrevUse = pixIn.lineStart ? notchOut : notchPrev_q;
    decimOut     = decimOn ? 8'((9'(notchOut) + 9'(notchPrevUse)) >> 1) : notchOut;
    gain9    = {actCtrl[LCADJ_BIT_LGAIN_TOP], lumaGainLow_q};
    gainProd = 17'(decimOut) * 17'(gain9);
    scaled   = (33'(gainProd) * 33'(LCADJ_GAIN_RECIP)) >> LCADJ_GAIN_SHIFT;
    gainOut  = (scaled > 33'(LCADJ_LUMA_MAX)) ? LCADJ_LUMA_MAX : scaled[7:0];
    // sign-extended offset, -128..+127 in single codes
    offsetSum = signed'({2'b00, gainOut}) + 10'(signed'(lumaOffset_q));
    // count from sync fall, pixel 0 at lineStart
    pixIdx     = pixIn.lineStart ? 10'h000 : 10'(pixCount_q + 1'b1);
    pixCount_d = accept ? pixIdx : pixCount_q;
    lumaPrev_d  = accept ? pixIn.luma : lumaPrev_q;
    notchPrev_d = accept ? notchOut : notchPrev_q;
    curOdd_d    = accept ? pixIn.oddField : curOdd_q;
    cAdcOn_d    = accept ? actCtrl[LCADJ_BIT_YC_INPUT] : cAdcOn_q;
    uTop_d      = accept ? actCtrl[LCADJ_BIT_UGAIN_TOP] : uTop_q;
    vTop_d      = accept ? actCtrl[LCADJ_BIT_VGAIN_TOP] : vTop_q;
    vidNext.lineStart = pixIn.lineStart;
    vidNext.oddField  = pixIn.oddField;
    vidNext.active    = (pixIdx >= hStartDelay_q);
    vidNext.isCb      = ~(pixIdx[0] ^ actCtrl[LCADJ_BIT_ORDER_INVERT]);
    vidNext.chroma    = vidNext.isCb ? pixIn.cb : pixIn.cr;
    if (offsetSum < 10'sd0) begin
      vidNext.luma = 8'h00;
    end else if (offsetSum > signed'({2'b00, LCADJ_LUMA_MAX})) begin
      vidNext.luma = LCADJ_LUMA_MAX;
    end else begin
      vidNext.luma = offsetSum[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lumaPrev_q  <= 8'h00;
      notchPrev_q <= 8'h00;
      pixCount_q  <= 10'h000;
      curOdd_q    <= 1'b0;
      cAdcOn_q    <= 1'b0;
      uTop_q      <= 1'b0;
      vTop_q      <= 1'b0;
    end else begin
      lumaPrev_q  <= lumaPrev_d;
      notchPrev_q <= notchPrev_d;
      pixCount_q  <= pixCount_d;
      curOdd_q    <= curOdd_d;
      cAdcOn_q    <= cAdcOn_d;
      uTop_q      <= uTop_d;
      vTop_q      <= vTop_d;
    end
  end

  lcadj_buf2 #(
    .WIDTH ($bits(lcadj_vid_t)),
    .DEPTH (BUF_DEPTH)
  ) outBuf (
    .clock    (clock),
    .srst     (srst),
    .inValid  (pixInValid),
    .inReady  (bufInReady),
    .inData   (vidNext),
    .outValid (vidOutValid),
    .outReady (vidOutReady),
    .outData  (vidOut)
  );

  assign pixInReady  = bufInReady;
  assign cAdcOn      = cAdcOn_q;
  assign uGainTopBit = uTop_q;
  assign vGainTopBit = vTop_q;
endmodule

// [verification/lcadj_properties.sv]
// checker: bus and stream timing properties of the top module
`timescale 1ns/10ps
module lcadj_properties
  import lcadj_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  srst,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  pixInValid,
  input wire logic                  pixInReady,
  input wire lcadj_pkg::lcadj_vid_t vidOut,
  input wire logic                  vidOutValid,
  input wire logic                  vidOutReady
);
  logic rdTk;

  assign rdTk = hsel & htrans[1] & hready & ~hwrite;

  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);

  // read address phase taken at a word index
  sequence rdAt(logic [9:0] a);
    rdTk && haddr[11:2] == a;
  endsequence

  sequence stalled;
    vidOutValid && !vidOutReady;
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  chk_rdata_stands: assert property (!rdTk |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_offset_width: assert property (rdAt(10'h00a) |=> hrdata[31:8] == 24'h0)
    else $error("offset read has upper bits set");
  chk_ctrl_width: assert property ((rdAt(10'h00b) or rdAt(10'h02b)) |=> hrdata[31:8] == 24'h0)
    else $error("control read has upper bits set");
  chk_out_holds: assert property (stalled |=> vidOutValid && $stable(vidOut))
    else $error("output word dropped or changed while stalled");
  chk_take_answer: assert property (pixInValid && pixInReady && !vidOutValid |=> vidOutValid)
    else $error("no output one cycle after take");
  chk_full_stays: assert property (!pixInReady && !vidOutReady |=> !pixInReady)
    else $error("ready rose while full and stalled");
  chk_ready_back: assert property (!pixInReady && vidOutValid && vidOutReady |-> ##[1:2] pixInReady)
    else $error("ready not back after pop");
endmodule

// [verification/lcadj_tb_top.sv]
// bench: register and pixel stream tests of the top module
`timescale 1ns/10ps
module lcadj_tb_top;
  import lcadj_pkg::*;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  lcadj_pix_t  pixIn = '0;
  logic        pixInValid = 1'b0;
  logic        pixInReady;
  lcadj_vid_t  vidOut;
  logic        vidOutValid;
  logic        vidOutReady = 1'b1;
  logic        cAdcOn;
  logic        uGainTopBit;
  logic        vGainTopBit;
  int          fails = 0;
  int          checkCount = 0;
  int          cyc = 0;

  assign hready = hreadyout;
  always #50 clock = ~clock;

  lcadj_top lcadj_top_i (.clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .pixIn, .pixInValid, .pixInReady, .vidOut, .vidOutValid, .vidOutReady, .cAdcOn,
    .uGainTopBit, .vGainTopBit);

  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    check(nm, r, e);
  endtask

  // push one pixel, wait for its output word
  task automatic px(input logic ls, input logic od, input logic [7:0] y, output lcadj_vid_t v);
    pixIn <= '{ls, od, y, 8'h11, 8'h22};
    pixInValid <= 1'b1;
    do @(posedge clock); while (pixInReady !== 1'b1);
    pixInValid <= 1'b0;
    do @(posedge clock); while (vidOutValid !== 1'b1);
    v = vidOut;
  endtask

  // gain, saturate, add signed offset, clamp
  function automatic logic [31:0] ey(input logic [7:0] y, input logic [8:0] gn, input logic [7:0] o);
    int g;
    g = (y * gn * LCADJ_GAIN_RECIP) >> LCADJ_GAIN_SHIFT;
    g = (g > 255 ? 255 : g) + $signed(o);
    return g < 0 ? 32'h0 : g > 255 ? 32'hff : 32'(g);
  endfunction

  initial begin
    lcadj_vid_t v;
    int n;
    logic [7:0] ofs [5] = '{8'h80, 8'hff, 8'h00, 8'h01, 8'h7f};
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rdc("offset reset", 12'h028, 32'h0);
    rdc("even reset", 12'h02c, 32'h20);
    rdc("odd reset", 12'h0ac, 32'h20);
    rdc("gain low reset", 12'h030, {24'h0, LCADJ_RST_LUMA_GAIN_LO});
    rdc("delay reset", 12'h040, {22'h0, LCADJ_RST_HSTART_DELAY});
    wr(12'h100, 32'hff);
    rdc("unmapped", 12'h100, 32'h0);
    wr(12'h02c, 32'hffff_ffa0);
    rdc("even rw", 12'h02c, 32'ha0);
    rdc("odd apart", 12'h0ac, 32'h20);
    for (int k = 0; k < 5; k++) begin
      wr(12'h028, {24'h0, ofs[k]});
      rdc("offset rw", 12'h028, {24'h0, ofs[k]});
      px(1'b1, 1'b0, 8'hc8, v);
      check("luma high", 32'(v.luma), ey(8'hc8, 9'hd8, ofs[k]));
      px(1'b1, 1'b0, 8'h0a, v);
      check("luma low", 32'(v.luma), ey(8'h0a, 9'hd8, ofs[k]));
    end
    wr(12'h028, 32'h0);
    wr(12'h02c, 32'h20);
    px(1'b1, 1'b0, 8'h64, v);
    px(1'b0, 1'b0, 8'hc8, v);
    check("notch", 32'(v.luma), ey(8'h96, 9'hd8, 8'h0));
    wr(12'h02c, 32'h60);
    px(1'b1, 1'b0, 8'h64, v);
    px(1'b0, 1'b0, 8'hc8, v);
    check("yc luma", 32'(v.luma), ey(8'hc8, 9'hd8, 8'h0));
    check("adc yc", 32'(cAdcOn), 32'h1);
    wr(12'h02c, 32'h80);
    px(1'b1, 1'b0, 8'h64, v);
    px(1'b0, 1'b0, 8'hc8, v);
    check("decim", 32'(v.luma), ey(8'h96, 9'hd8, 8'h0));
    wr(12'h02c, 32'ha4);
    px(1'b1, 1'b0, 8'h64, v);
    check("gain top", 32'(v.luma), ey(8'h64, 9'h1d8, 8'h0));
    wr(12'h02c, 32'ha2);
    wr(12'h0ac, 32'he1);
    px(1'b1, 1'b1, 8'h64, v);
    check("odd ctl", {cAdcOn, uGainTopBit, vGainTopBit}, 32'h5);
    check("odd flags", {v.lineStart, v.oddField}, 32'h3);
    rdc("status", 12'h044, 32'h00000c00);
    px(1'b1, 1'b0, 8'h64, v);
    check("even ctl", {cAdcOn, uGainTopBit, vGainTopBit}, 32'h2);
    wr(12'h02c, 32'ha0);
    px(1'b1, 1'b0, 8'h64, v);
    check("first cb", {v.isCb, v.chroma}, 32'h111);
    px(1'b0, 1'b0, 8'h64, v);
    check("then cr", {v.isCb, v.chroma}, 32'h022);
    wr(12'h02c, 32'hb0);
    px(1'b1, 1'b0, 8'h64, v);
    check("inverted", {v.isCb, v.chroma}, 32'h022);
    wr(12'h040, 32'h1);
    px(1'b1, 1'b0, 8'h64, v);
    check("in delay", 32'(v.active), 32'h0);
    px(1'b0, 1'b0, 8'h64, v);
    check("odd delay", {v.active, v.isCb}, 32'h3);
    vidOutReady <= 1'b0;
    pixIn <= '{1'b1, 1'b0, 8'h64, 8'h11, 8'h22};
    pixInValid <= 1'b1;
    n = 0;
    repeat (4) begin
      @(posedge clock);
      if (pixInReady === 1'b1) n++;
    end
    check("fill", 32'(n), 32'h2);
    pixInValid <= 1'b0;
    vidOutReady <= 1'b1;
    n = 0;
    repeat (4) begin
      @(posedge clock);
      if (vidOutValid === 1'b1) n++;
    end
    check("drain", 32'(n), 32'h2);
    summarize();
  end
endmodule

bind lcadj_top lcadj_properties lcadj_properties_i (.clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .pixInValid, .pixInReady, .vidOut, .vidOutValid, .vidOutReady);
